// ---- hdl/tbf_pkg.sv ----
// Shared constants, types and helpers of the triple bus FIFO block.
// Assumes a single clock domain shared by all three ports.
package tbf_pkg;

  // ==========================================================================
  // Widths and depths
  localparam int TBF_A_WIDTH = 36;
  localparam int TBF_BC_WIDTH = 18;
  localparam int TBF_DEPTH_DEF = 2048;

  // ==========================================================================
  // Values after reset
  localparam logic TBF_RST_BIG_ENDIAN = 1'b0;
  localparam logic TBF_RST_FALL_THROUGH_MODE = 1'b0;
  localparam logic TBF_RST_FLAG = 1'b0;
  localparam logic TBF_RST_VALID = 1'b0;

  // ==========================================================================
  // Half-word sequencing state of ports B and C.
  typedef enum logic {
    TBF_HALF_WHOLE = 1'b0,
    TBF_HALF_SPLIT = 1'b1
  } tbf_half_t;

  // Picks the half of a port A word that goes out first or second.
  function automatic logic [TBF_BC_WIDTH-1:0] tbf_pick_half(
      input logic [TBF_A_WIDTH-1:0] word,
      input logic big,
      input logic second);
    logic upper;
    upper = big ^ second;
    return upper ? word[TBF_A_WIDTH-1:TBF_BC_WIDTH] : word[TBF_BC_WIDTH-1:0];
  endfunction : tbf_pick_half

  // Joins two halves received on port C into one port A word.
  function automatic logic [TBF_A_WIDTH-1:0] tbf_join(
      input logic [TBF_BC_WIDTH-1:0] first,
      input logic [TBF_BC_WIDTH-1:0] second,
      input logic big);
    return big ? {first, second} : {second, first};
  endfunction : tbf_join

endpackage : tbf_pkg

// ---- hdl/tbf_fifo_if.sv ----
// Carrier between a FIFO store and the port logic that fills and drains it.
// Assumes store and user share one clock.
`timescale 1ns/1ps
interface tbf_fifo_if #(
  parameter int W = 36,
  parameter int AW = 11
);
  logic clear;
  logic push;
  logic [W-1:0] push_data;
  logic pop;
  logic [W-1:0] head_data;
  logic [AW:0] count;
  logic full;
  logic empty;

  modport store (input clear, input push, input push_data, input pop,
                 output head_data, output count, output full, output empty);
  modport user (output clear, output push, output push_data, output pop,
                input head_data, input count, input full, input empty);
endinterface : tbf_fifo_if

// ---- hdl/tbf_fifo_store.sv ----
// Word store of one FIFO: memory array, pointers and word count.
// Assumes pushes and pops are already gated by the user against full/empty.
`timescale 1ns/1ps
module tbf_fifo_store
  import tbf_pkg::*;
#(
  parameter int DEPTH = TBF_DEPTH_DEF,
  parameter int W = TBF_A_WIDTH
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  tbf_fifo_if.store f
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [AW:0] count_r;
  logic push_ok;
  logic pop_ok;

  // Accepted moves; a full store drops pushes, an empty one drops pops.
  assign push_ok = f.push && (count_r != DEPTH_C) && !f.clear;
  assign pop_ok = f.pop && (count_r != '0) && !f.clear;

  // Memory write.
  always_ff @(posedge mclk_i) begin
    if (push_ok) begin
      mem[wptr_r] <= f.push_data;
    end
  end

  // Pointers and count.
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wptr_r <= '0;
      rptr_r <= '0;
      count_r <= '0;
    end else if (f.clear) begin
      wptr_r <= '0;
      rptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push_ok) wptr_r <= wptr_r + 1'b1;
      if (pop_ok) rptr_r <= rptr_r + 1'b1;
      if (push_ok && !pop_ok) count_r <= count_r + 1'b1;
      else if (pop_ok && !push_ok) count_r <= count_r - 1'b1;
    end
  end

  // Status and head word seen by the user.
  assign f.head_data = mem[rptr_r];
  assign f.count = count_r;
  assign f.full = (count_r == DEPTH_C);
  assign f.empty = (count_r == '0);
endmodule : tbf_fifo_store

// ---- hdl/tbf_level_flags.sv ----
// Registered almost-empty and almost-full flags of one FIFO.
// Assumes offsets are held stable by the surrounding system.
`timescale 1ns/1ps
module tbf_level_flags
  import tbf_pkg::*;
#(
  parameter int DEPTH = TBF_DEPTH_DEF,
  parameter int CW = 12
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic [CW-1:0] count_i,
  input wire logic [CW-1:0] empty_offset_i,
  input wire logic [CW-1:0] full_offset_i,
  output logic almost_empty_n_o,
  output logic almost_full_n_o
);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  logic [CW-1:0] free_slots;

  // Free locations left in the store.
  assign free_slots = DEPTH_C - count_i;

  // Flags go low at or below their offsets.
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      almost_empty_n_o <= TBF_RST_FLAG;
      almost_full_n_o <= ~TBF_RST_FLAG;
    end else begin
      almost_empty_n_o <= !(count_i <= empty_offset_i);
      almost_full_n_o <= !(free_slots <= full_offset_i);
    end
  end
endmodule : tbf_level_flags

// ---- hdl/tbf_triple_port.sv ----
// Triple bus FIFO: 36-bit two-way port A, 18-bit output port B, 18-bit input port C.
// Assumes all three port clocks are the one clock mclk_i and all inputs are synchronous.
`timescale 1ns/1ps
module tbf_triple_port
  import tbf_pkg::*;
#(
  parameter int DEPTH = TBF_DEPTH_DEF
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic master_reset_n_i,
  input wire logic endian_timing_select_i,
  input wire logic porta_select_n_i,
  input wire logic porta_transfer_gate_i,
  input wire logic porta_write_i,
  input wire logic [TBF_A_WIDTH-1:0] side_a_data_i,
  output logic [TBF_A_WIDTH-1:0] side_a_data_o,
  output logic side_a_data_oe_o,
  output logic porta_full_or_inready_o,
  output logic porta_empty_or_outready_o,
  output logic porta_almost_full_n_o,
  output logic porta_almost_empty_n_o,
  input wire logic portb_select_n_i,
  input wire logic portb_read_i,
  output logic [TBF_BC_WIDTH-1:0] side_b_out_data_o,
  output logic side_b_out_data_oe_o,
  output logic portb_empty_or_outready_o,
  output logic portb_almost_empty_n_o,
  input wire logic portc_write_i,
  input wire logic [TBF_BC_WIDTH-1:0] side_c_in_data_i,
  output logic portc_full_or_inready_o,
  output logic portc_almost_full_n_o,
  input wire logic [$clog2(DEPTH):0] empty_offset_first_i,
  input wire logic [$clog2(DEPTH):0] empty_offset_second_i,
  input wire logic [$clog2(DEPTH):0] full_offset_first_i,
  input wire logic [$clog2(DEPTH):0] full_offset_second_i
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  // ==========================================================================
  // Elaboration check
  // The pointers wrap naturally, so the depth must be a power of two.
  if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("tbf_triple_port: DEPTH must be a power of two of at least 4.");
  end

  // ==========================================================================
  // Declarations
  logic big_endian_r;
  logic fall_through_mode_r;
  logic clear;
  logic a_taken;
  logic a_rd_req;
  logic a_advance;
  logic a_valid_r;
  logic a_valid_nxt;
  logic [TBF_A_WIDTH-1:0] a_dout_r;
  logic b_taken;
  logic b_advance;
  logic b_valid_r;
  logic b_valid_nxt;
  logic b_pop;
  tbf_half_t b_state_r;
  tbf_half_t b_state_nxt;
  logic [TBF_A_WIDTH-1:0] b_hold_r;
  logic [TBF_BC_WIDTH-1:0] b_dout_r;
  logic [TBF_BC_WIDTH-1:0] b_dout_nxt;
  logic c_ok;
  tbf_half_t c_state_r;
  logic [TBF_BC_WIDTH-1:0] c_hold_r;

  tbf_fifo_if #(.W(TBF_A_WIDTH), .AW(AW)) first_if ();
  tbf_fifo_if #(.W(TBF_A_WIDTH), .AW(AW)) second_if ();

  // ==========================================================================
  // FIFO stores
  // The first store carries port A to port B, the second port C to port A.
  tbf_fifo_store #(.DEPTH(DEPTH), .W(TBF_A_WIDTH)) u_first (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .f(first_if.store)
  );

  tbf_fifo_store #(.DEPTH(DEPTH), .W(TBF_A_WIDTH)) u_second (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .f(second_if.store)
  );

  // ==========================================================================
  // Mode selection
  // Master reset empties both stores.
  assign clear = !master_reset_n_i;
  assign first_if.clear = clear;
  assign second_if.clear = clear;

  // Endian order is caught during master reset, timing mode after it.
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      big_endian_r <= TBF_RST_BIG_ENDIAN;
      fall_through_mode_r <= TBF_RST_FALL_THROUGH_MODE;
    end else if (clear) begin
      big_endian_r <= endian_timing_select_i;
    end else begin
      fall_through_mode_r <= !endian_timing_select_i;
    end
  end

  // ==========================================================================
  // Port A
  // A transfer needs select low and enable high on the clock edge.
  assign a_taken = !porta_select_n_i && porta_transfer_gate_i;
  assign a_rd_req = a_taken && !porta_write_i;

  // Writes from port A feed the first store, refused while it is full.
  assign first_if.push = a_taken && porta_write_i && !first_if.full;
  assign first_if.push_data = side_a_data_i;

  // Standard timing moves on a read; fall-through also preloads an idle output.
  assign a_advance = fall_through_mode_r ? (!a_valid_r || a_rd_req) : a_rd_req;
  assign second_if.pop = a_advance && !second_if.empty && !clear;

  // Next value of the output-holds-valid-data state.
  always_comb begin
    a_valid_nxt = a_valid_r;
    if (clear) begin
      a_valid_nxt = 1'b0;
    end else if (a_advance) begin
      a_valid_nxt = !second_if.empty;
    end
  end

  // Output word register and its valid state.
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      a_valid_r <= TBF_RST_VALID;
      a_dout_r <= '0;
    end else begin
      a_valid_r <= a_valid_nxt;
      if (second_if.pop) a_dout_r <= second_if.head_data;
    end
  end

  // Drivers are enabled only while selected and in read direction.
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      side_a_data_oe_o <= 1'b0;
    end else begin
      side_a_data_oe_o <= !porta_select_n_i && !porta_write_i;
    end
  end
  assign side_a_data_o = a_dout_r;

  // Port A full/ready and empty/ready flags.
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      porta_full_or_inready_o <= TBF_RST_FLAG;
      porta_empty_or_outready_o <= TBF_RST_FLAG;
    end else begin
      porta_full_or_inready_o <= !first_if.full && !clear;
      porta_empty_or_outready_o <= fall_through_mode_r ? a_valid_nxt : !second_if.empty;
    end
  end

  // ==========================================================================
  // Port B
  // A read needs select low and read high on the clock edge.
  assign b_taken = !portb_select_n_i && portb_read_i;
  assign b_advance = fall_through_mode_r ? (!b_valid_r || b_taken) : b_taken;

  // Each stored word leaves as two halves in the chosen endian order.
  always_comb begin
    b_valid_nxt = b_valid_r;
    b_state_nxt = b_state_r;
    b_dout_nxt = b_dout_r;
    b_pop = 1'b0;
    if (clear) begin
      b_valid_nxt = 1'b0;
      b_state_nxt = TBF_HALF_WHOLE;
    end else if (b_advance) begin
      case (b_state_r)
        TBF_HALF_SPLIT: begin
          b_dout_nxt = tbf_pick_half(b_hold_r, big_endian_r, 1'b1);
          b_state_nxt = TBF_HALF_WHOLE;
          b_valid_nxt = 1'b1;
        end
        TBF_HALF_WHOLE: begin
          if (!first_if.empty) begin
            b_pop = 1'b1;
            b_dout_nxt = tbf_pick_half(first_if.head_data, big_endian_r, 1'b0);
            b_state_nxt = TBF_HALF_SPLIT;
            b_valid_nxt = 1'b1;
          end else begin
            b_valid_nxt = 1'b0;
          end
        end
        default: begin
          b_state_nxt = TBF_HALF_WHOLE;
        end
      endcase
    end
  end
  assign first_if.pop = b_pop;

  // Port B sequencing registers.
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      b_valid_r <= TBF_RST_VALID;
      b_state_r <= TBF_HALF_WHOLE;
      b_dout_r <= '0;
      b_hold_r <= '0;
    end else begin
      b_valid_r <= b_valid_nxt;
      b_state_r <= b_state_nxt;
      b_dout_r <= b_dout_nxt;
      if (b_pop) b_hold_r <= first_if.head_data;
    end
  end
  assign side_b_out_data_o = b_dout_r;

  // Port B output enable and empty/ready flag.
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      side_b_out_data_oe_o <= 1'b0;
      portb_empty_or_outready_o <= TBF_RST_FLAG;
    end else begin
      side_b_out_data_oe_o <= !portb_select_n_i;
      portb_empty_or_outready_o <= fall_through_mode_r ? b_valid_nxt :
          ((b_state_nxt == TBF_HALF_SPLIT) || !first_if.empty);
    end
  end

  // ==========================================================================
  // Port C
  // Halves are taken while the second store has room for the word.
  assign c_ok = portc_write_i && !second_if.full && !clear;
  assign second_if.push = c_ok && (c_state_r == TBF_HALF_SPLIT);
  assign second_if.push_data = tbf_join(c_hold_r, side_c_in_data_i, big_endian_r);

  // First half is held; second half completes and stores the word.
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      c_state_r <= TBF_HALF_WHOLE;
      c_hold_r <= '0;
    end else if (clear) begin
      c_state_r <= TBF_HALF_WHOLE;
    end else if (c_ok) begin
      case (c_state_r)
        TBF_HALF_WHOLE: begin
          c_hold_r <= side_c_in_data_i;
          c_state_r <= TBF_HALF_SPLIT;
        end
        TBF_HALF_SPLIT: begin
          c_state_r <= TBF_HALF_WHOLE;
        end
        default: begin
          c_state_r <= TBF_HALF_WHOLE;
        end
      endcase
    end
  end

  // Port C full/ready flag.
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      portc_full_or_inready_o <= TBF_RST_FLAG;
    end else begin
      portc_full_or_inready_o <= !second_if.full && !clear;
    end
  end

  // ==========================================================================
  // Almost flags
  // First store: port B almost-empty and port A almost-full.
  tbf_level_flags #(.DEPTH(DEPTH), .CW(CW)) u_first_flags (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .count_i(first_if.count),
    .empty_offset_i(empty_offset_first_i),
    .full_offset_i(full_offset_first_i),
    .almost_empty_n_o(portb_almost_empty_n_o),
    .almost_full_n_o(porta_almost_full_n_o)
  );

  // Second store: port A almost-empty and port C almost-full.
  tbf_level_flags #(.DEPTH(DEPTH), .CW(CW)) u_second_flags (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .count_i(second_if.count),
    .empty_offset_i(empty_offset_second_i),
    .full_offset_i(full_offset_second_i),
    .almost_empty_n_o(porta_almost_empty_n_o),
    .almost_full_n_o(portc_almost_full_n_o)
  );

endmodule : tbf_triple_port

// ---- test/tbf_triple_port_chk.sv ----
// Concurrent checks on the ports of the triple bus FIFO top.
// Assumes the one clock mclk_i and the async reset arst_n_i.
`timescale 1ns/1ps
module tbf_triple_port_chk
  import tbf_pkg::*;
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic master_reset_n_i,
  input wire logic endian_timing_select_i,
  input wire logic porta_select_n_i,
  input wire logic porta_transfer_gate_i,
  input wire logic porta_write_i,
  input wire logic [TBF_A_WIDTH-1:0] side_a_data_o,
  input wire logic side_a_data_oe_o,
  input wire logic porta_full_or_inready_o,
  input wire logic porta_empty_or_outready_o,
  input wire logic porta_almost_full_n_o,
  input wire logic porta_almost_empty_n_o,
  input wire logic portb_select_n_i,
  input wire logic portb_read_i,
  input wire logic [TBF_BC_WIDTH-1:0] side_b_out_data_o,
  input wire logic side_b_out_data_oe_o,
  input wire logic portb_empty_or_outready_o,
  input wire logic portb_almost_empty_n_o,
  input wire logic portc_full_or_inready_o,
  input wire logic portc_almost_full_n_o
);
  // ==========================================================================
  // Settling helper and assertions
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  logic [1:0] mr_cnt_r;
  logic ok;
  logic std;
  // Counts cycles since master reset ended, so flags are only judged once valid.
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mr_cnt_r <= 2'h0;
    end else if (!master_reset_n_i) begin
      mr_cnt_r <= 2'h0;
    end else if (mr_cnt_r != 2'h3) begin
      mr_cnt_r <= mr_cnt_r + 2'h1;
    end
  end
  // Settled operation, and settled standard timing.
  assign ok = (mr_cnt_r == 2'h3) && master_reset_n_i;
  assign std = ok && endian_timing_select_i;

  chk_a_oe_sel: assert property (porta_select_n_i |=> !side_a_data_oe_o)
    else $error("port A drives while deselected");
  chk_a_oe_dir: assert property (porta_write_i |=> !side_a_data_oe_o)
    else $error("port A drives during a write");
  chk_b_oe_sel: assert property (portb_select_n_i |=> !side_b_out_data_oe_o)
    else $error("port B drives while deselected");
  chk_a_data_hold: assert property (std && (porta_select_n_i || !porta_transfer_gate_i ||
    porta_write_i) |=> $stable(side_a_data_o))
    else $error("port A data moved without a read");
  chk_b_data_hold: assert property (std && (portb_select_n_i || !portb_read_i)
    |=> $stable(side_b_out_data_o))
    else $error("port B data moved without a read");
  chk_a_ae_level: assert property ((ok && porta_almost_empty_n_o) [*2]
    |-> porta_empty_or_outready_o)
    else $error("port A above almost empty yet empty");
  chk_b_ae_level: assert property ((ok && portb_almost_empty_n_o) [*2]
    |-> portb_empty_or_outready_o)
    else $error("port B above almost empty yet empty");
  chk_a_af_level: assert property ((ok && !porta_full_or_inready_o) [*2]
    |-> !porta_almost_full_n_o)
    else $error("port A full but not almost full");
  chk_c_af_level: assert property ((ok && !portc_full_or_inready_o) [*2]
    |-> !portc_almost_full_n_o)
    else $error("port C full but not almost full");
  chk_mr_clear: assert property (!master_reset_n_i [*3]
    |-> !porta_empty_or_outready_o && !portb_empty_or_outready_o)
    else $error("data shown during master reset");

  cov_a_full: cover property (ok && !porta_full_or_inready_o);
  cov_c_full: cover property (ok && !portc_full_or_inready_o);
  cov_b_read: cover property (!portb_select_n_i && portb_read_i && portb_empty_or_outready_o);
endmodule : tbf_triple_port_chk

bind tbf_triple_port tbf_triple_port_chk u_chk (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
  .master_reset_n_i(master_reset_n_i), .endian_timing_select_i(endian_timing_select_i),
  .porta_select_n_i(porta_select_n_i), .porta_transfer_gate_i(porta_transfer_gate_i),
  .porta_write_i(porta_write_i), .side_a_data_o(side_a_data_o),
  .side_a_data_oe_o(side_a_data_oe_o), .porta_full_or_inready_o(porta_full_or_inready_o),
  .porta_empty_or_outready_o(porta_empty_or_outready_o),
  .porta_almost_full_n_o(porta_almost_full_n_o),
  .porta_almost_empty_n_o(porta_almost_empty_n_o), .portb_select_n_i(portb_select_n_i),
  .portb_read_i(portb_read_i), .side_b_out_data_o(side_b_out_data_o),
  .side_b_out_data_oe_o(side_b_out_data_oe_o),
  .portb_empty_or_outready_o(portb_empty_or_outready_o),
  .portb_almost_empty_n_o(portb_almost_empty_n_o),
  .portc_full_or_inready_o(portc_full_or_inready_o),
  .portc_almost_full_n_o(portc_almost_full_n_o));

// ---- test/tbf_far_side.sv ----
// Far side model: a reader on port B and a writer on port C.
// Assumes requests are launched at the falling edge of the shared clock.
`timescale 1ns/1ps
module tbf_far_side
  import tbf_pkg::*;
(
  input wire logic mclk_i,
  output logic portb_select_n_o,
  output logic portb_read_o,
  input wire logic [TBF_BC_WIDTH-1:0] side_b_out_data_i,
  input wire logic portb_outready_i,
  output logic portc_write_o,
  output logic [TBF_BC_WIDTH-1:0] side_c_in_data_o,
  input wire logic portc_inready_i
);
  // ==========================================================================
  // Idle levels and transfer tasks
  initial begin
    portb_select_n_o = 1'b1;
    portb_read_o = 1'b0;
    portc_write_o = 1'b0;
    side_c_in_data_o = 18'h3ffff;
  end

  // Writes one half once there is room; the idle bus carries the inverse value.
  // One idle edge first, so back-to-back calls never move the strobe twice at once.
  task automatic push_half(input logic [TBF_BC_WIDTH-1:0] h, input int gap);
    @(negedge mclk_i);
    repeat (gap) @(negedge mclk_i);
    for (int i = 0; i < 64 && portc_inready_i !== 1'b1; i++) @(negedge mclk_i);
    portc_write_o = 1'b1;
    side_c_in_data_o = h;
    @(negedge mclk_i);
    portc_write_o = 1'b0;
    side_c_in_data_o = ~h;
  endtask : push_half

  // Reads one half once data is shown, deselects the port, then takes the half.
  task automatic pull_half(output logic [TBF_BC_WIDTH-1:0] h, input int gap);
    repeat (gap) @(negedge mclk_i);
    for (int i = 0; i < 64 && portb_outready_i !== 1'b1; i++) @(negedge mclk_i);
    portb_select_n_o = 1'b0;
    portb_read_o = 1'b1;
    @(negedge mclk_i);
    portb_read_o = 1'b0;
    portb_select_n_o = 1'b1;
    @(negedge mclk_i);
    h = side_b_out_data_i;
  endtask : pull_half
endmodule : tbf_far_side

// ---- test/tb_top.sv ----
// Self-checking bench of the triple bus FIFO top, built with a depth of eight.
// Assumes the far side model drives ports B and C; port A is driven here.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch at %0t got %h exp %h", $time, (g), (e)); end end
module tb_top
  import tbf_pkg::*;
;
  // ==========================================================================
  // Stimulus signals and instances
  localparam int DEPTH = 8;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic mrst_n = 1'b0;
  logic ets = 1'b0;
  logic a_sel_n = 1'b1;
  logic a_gate = 1'b0;
  logic a_wr = 1'b0;
  logic [TBF_A_WIDTH-1:0] a_din = 36'h000000000;
  logic [TBF_A_WIDTH-1:0] a_dout;
  logic a_oe, a_full, a_empty, a_af_n, a_ae_n, b_sel_n, b_rd, b_oe, b_empty, b_ae_n;
  logic c_wr, c_full, c_af_n;
  logic [TBF_BC_WIDTH-1:0] b_dout, c_din;
  int err_count = 0;
  int n_compared = 0;

  // Clock of 4 ns.
  always #2 mclk = ~mclk;

  tbf_triple_port #(.DEPTH(DEPTH)) DUT (.mclk_i(mclk), .arst_n_i(arst_n),
    .master_reset_n_i(mrst_n), .endian_timing_select_i(ets), .porta_select_n_i(a_sel_n),
    .porta_transfer_gate_i(a_gate), .porta_write_i(a_wr), .side_a_data_i(a_din),
    .side_a_data_o(a_dout), .side_a_data_oe_o(a_oe), .porta_full_or_inready_o(a_full),
    .porta_empty_or_outready_o(a_empty), .porta_almost_full_n_o(a_af_n),
    .porta_almost_empty_n_o(a_ae_n), .portb_select_n_i(b_sel_n), .portb_read_i(b_rd),
    .side_b_out_data_o(b_dout), .side_b_out_data_oe_o(b_oe),
    .portb_empty_or_outready_o(b_empty), .portb_almost_empty_n_o(b_ae_n),
    .portc_write_i(c_wr), .side_c_in_data_i(c_din), .portc_full_or_inready_o(c_full),
    .portc_almost_full_n_o(c_af_n), .empty_offset_first_i(4'h2),
    .empty_offset_second_i(4'h2), .full_offset_first_i(4'h2), .full_offset_second_i(4'h2));

  tbf_far_side FAR (.mclk_i(mclk), .portb_select_n_o(b_sel_n), .portb_read_o(b_rd),
    .side_b_out_data_i(b_dout), .portb_outready_i(b_empty), .portc_write_o(c_wr),
    .side_c_in_data_o(c_din), .portc_inready_i(c_full));

  // ==========================================================================
  // Helpers
  function automatic logic [TBF_A_WIDTH-1:0] wv(input int i);
    return {18'h2a000 + 18'(i), 18'h15000 - 18'(i)};
  endfunction : wv

  // Master reset with the endian level, then the timing level held static.
  task automatic init(input logic big, input logic std_t = 1'b1);
    @(negedge mclk);
    mrst_n = 1'b0;
    ets = big;
    repeat (4) @(negedge mclk);
    mrst_n = 1'b1;
    ets = std_t;
    repeat (2) @(negedge mclk);
  endtask : init

  task automatic a_write(input logic [TBF_A_WIDTH-1:0] w);
    @(negedge mclk);
    a_sel_n = 1'b0;
    a_gate = 1'b1;
    a_wr = 1'b1;
    a_din = w;
    @(negedge mclk);
    a_gate = 1'b0;
    a_din = ~w;
  endtask : a_write

  task automatic a_read(output logic [TBF_A_WIDTH-1:0] w);
    for (int i = 0; i < 64 && a_empty !== 1'b1; i++) @(negedge mclk);
    a_sel_n = 1'b0;
    a_gate = 1'b1;
    a_wr = 1'b0;
    @(negedge mclk);
    a_gate = 1'b0;
    @(negedge mclk);
    w = a_dout;
  endtask : a_read

  // ==========================================================================
  // Scenarios
  // Writes with the select high or the gate low must not reach the first FIFO.
  task automatic sc_gating();
    @(negedge mclk);
    a_sel_n = 1'b1;
    a_gate = 1'b1;
    a_wr = 1'b1;
    a_din = 36'h123456789;
    @(negedge mclk);
    a_sel_n = 1'b0;
    a_gate = 1'b0;
    repeat (3) @(negedge mclk);
    `CHK(b_empty, 1'b0)
    `CHK(b_ae_n, 1'b0)
    `CHK(a_full, 1'b1)
    `CHK(a_oe, 1'b0)
  endtask : sc_gating

  // Fills the first FIFO past full, then drains it at port B, little endian.
  task automatic sc_fill_a();
    logic [TBF_BC_WIDTH-1:0] h;
    logic [TBF_A_WIDTH-1:0] w;
    for (int i = 0; i < DEPTH + 1; i++) a_write(wv(i));
    repeat (3) @(negedge mclk);
    `CHK(a_full, 1'b0)
    `CHK(a_af_n, 1'b0)
    `CHK(b_ae_n, 1'b1)
    for (int i = 0; i < 2 * DEPTH; i++) begin
      w = wv(i / 2);
      FAR.pull_half(h, i % 3);
      `CHK(h, i[0] ? w[35:18] : w[17:0])
    end
    repeat (3) @(negedge mclk);
    `CHK(b_empty, 1'b0)
    `CHK(b_ae_n, 1'b0)
    `CHK(a_full, 1'b1)
    `CHK(b_oe, 1'b0)
  endtask : sc_fill_a

  // Fills the second FIFO from port C, then drains it at port A.
  task automatic sc_fill_c();
    logic [TBF_A_WIDTH-1:0] w;
    logic [TBF_A_WIDTH-1:0] r;
    for (int i = 0; i < DEPTH; i++) begin
      w = wv(i + 16);
      FAR.push_half(w[17:0], i % 2);
      FAR.push_half(w[35:18], 0);
    end
    repeat (3) @(negedge mclk);
    `CHK(c_full, 1'b0)
    `CHK(c_af_n, 1'b0)
    `CHK(a_ae_n, 1'b1)
    for (int i = 0; i < DEPTH; i++) begin
      a_read(r);
      `CHK(r, wv(i + 16))
    end
    `CHK(a_oe, 1'b1)
    a_sel_n = 1'b1;
    repeat (3) @(negedge mclk);
    `CHK(a_oe, 1'b0)
    `CHK(a_empty, 1'b0)
    `CHK(a_ae_n, 1'b0)
    `CHK(c_full, 1'b1)
  endtask : sc_fill_c

  // Big endian: most significant half leaves port B first and enters port C first.
  task automatic sc_big();
    logic [TBF_BC_WIDTH-1:0] h;
    logic [TBF_A_WIDTH-1:0] w;
    logic [TBF_A_WIDTH-1:0] r;
    init(1'b1);
    w = wv(40);
    a_write(w);
    FAR.pull_half(h, 0);
    `CHK(h, w[35:18])
    FAR.pull_half(h, 2);
    `CHK(h, w[17:0])
    FAR.push_half(w[35:18], 0);
    FAR.push_half(w[17:0], 1);
    a_read(r);
    `CHK(r, w)
  endtask : sc_big

  // Fall-through: both read sides show their first data with no read request.
  task automatic sc_fall_through_mode();
    logic [TBF_BC_WIDTH-1:0] h;
    logic [TBF_A_WIDTH-1:0] w;
    init(1'b0, 1'b0);
    w = wv(50);
    a_write(w);
    FAR.push_half(w[17:0], 0);
    FAR.push_half(w[35:18], 0);
    repeat (2) @(negedge mclk);
    `CHK(a_empty, 1'b1)
    `CHK(a_dout, w)
    `CHK(a_full, 1'b1)
    `CHK(b_empty, 1'b1)
    `CHK(b_dout, w[17:0])
    FAR.pull_half(h, 0);
    `CHK(h, w[35:18])
    FAR.pull_half(h, 0);
    `CHK(b_empty, 1'b0)
  endtask : sc_fall_through_mode

  // ==========================================================================
  // Verdict, watchdog and main sequence
  task automatic close_out();
    if (err_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  // Cuts a hang well beyond the few hundred cycles the scenarios need.
  initial begin
    #20000;
    err_count++;
    close_out();
  end

  // Reset for five cycles, then the scenarios in order.
  initial begin
    repeat (5) @(negedge mclk);
    arst_n = 1'b1;
    init(1'b0);
    sc_gating();
    sc_fill_a();
    sc_fill_c();
    sc_big();
    sc_fall_through_mode();
    close_out();
  end
endmodule : tb_top
